// >>> logic/dsbo_top.sv
// sample fifo and bitstream output stage of a delta-sigma modulator
// Notes on behaviour
// - stopped clock freezes conversion and output level
// - zero input gives fifty percent ones
// - plus one volt gives ninety percent ones
// - minus one volt gives ten percent ones
// - clipped input gives zeros or ones apart from the markers
// - clipped stream carries opposite marker every 128
// - ones density follows clip-scaled input
// - plain-mode bitstream changes only on sample clock rise
// - coded mode gives a transition per bit
// - coded output is clock xor modulator bit
// - coded duty cycle follows sample clock
// - mode change while clock high inverts output
// - clip marker also present in coded mode
// - common-mode trip forces steady high output
// - chopper switches at sample clock over 32
`timescale 1ns/1ps

module dsbo_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != FULL);
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  // storage has no reset; only words behind count are ever read
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_r <= '0;
    end
    else if (push && !pop)
    begin
      count_r <= count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_r <= count_r - 1'b1;
    end
  end

  default clocking dflt_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  c_fifo_full: cover property (!in_ready ##1 out_ready);
endmodule // dsbo_fifo

module dsbo_top #(
  parameter int SETTLE_CYCLES = dsbo_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // pins from the filter side
  input wire logic sample_clock_in,
  input wire logic line_code_select,
  // analog front end
  input wire dsbo_pkg::dsbo_cm_t cm_trip,
  input wire logic s_valid,
  output logic s_ready,
  input wire dsbo_pkg::dsbo_sample_t s_data,
  // outputs
  output logic bitstream_out,
  output logic chopper_phase,
  output logic conversion_active,
  output logic stream_settled
);
  localparam int AW = dsbo_pkg::ACC_W;
  localparam int SW = dsbo_pkg::SAMPLE_W;
  localparam logic [dsbo_pkg::PAUSE_W-1:0] PAUSE_LIM =
    dsbo_pkg::PAUSE_W'(dsbo_pkg::PAUSE_CYCLES);
  localparam logic [dsbo_pkg::SETTLE_W-1:0] SETTLE_LAST =
    dsbo_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

  function automatic logic signed [AW-1:0] ext_mv(
    input logic signed [SW-1:0] v
  );
    return {{(AW-SW){v[SW-1]}}, v};
  endfunction

  logic clk_meta_r;
  logic clk_s_r;
  logic clk_d_r;
  logic mode_meta_r;
  logic mode_s_r;
  logic mode_d_r;
  dsbo_pkg::dsbo_cm_t cm_meta_r;
  dsbo_pkg::dsbo_cm_t cm_s_r;
  logic rise;
  logic mode_chg;
  logic f_valid;
  dsbo_pkg::dsbo_sample_t f_data;
  dsbo_pkg::dsbo_sample_t smp_r;
  logic signed [SW-1:0] vin;
  logic pos_clip;
  logic neg_clip;
  logic clipped_r;
  logic clip_pos_r;
  logic [dsbo_pkg::MARK_W-1:0] mark_cnt_r;
  logic signed [AW-1:0] i1_r;
  logic signed [AW-1:0] i2_r;
  logic signed [AW-1:0] fb;
  logic signed [AW-1:0] i1_nxt;
  logic signed [AW-1:0] i2_nxt;
  logic bit_r;
  logic fs_r;
  logic inv_r;
  logic dout_r;
  logic [dsbo_pkg::CHOP_W-1:0] chop_cnt_r;
  logic chop_r;
  logic [dsbo_pkg::PAUSE_W-1:0] pause_cnt_r;
  logic alive;
  logic active_r;
  logic [dsbo_pkg::SETTLE_W-1:0] settle_cnt_r;
  logic settled_r;

  // pins come from another clock, two flops before any use
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_meta_r <= 1'b0;
      clk_s_r <= 1'b0;
      clk_d_r <= 1'b0;
      mode_meta_r <= 1'b0;
      mode_s_r <= 1'b0;
      mode_d_r <= 1'b0;
      cm_meta_r <= '0;
      cm_s_r <= '0;
    end
    else
    begin
      clk_meta_r <= sample_clock_in;
      clk_s_r <= clk_meta_r;
      clk_d_r <= clk_s_r;
      mode_meta_r <= line_code_select;
      mode_s_r <= mode_meta_r;
      mode_d_r <= mode_s_r;
      cm_meta_r <= cm_trip;
      cm_s_r <= cm_meta_r;
    end
  end

  assign rise = clk_s_r && !clk_d_r;
  assign mode_chg = (mode_s_r != mode_d_r);

  // fifo drains one sample per sample clock; no clock means back-pressure
  dsbo_fifo #(
    .W($bits(dsbo_pkg::dsbo_sample_t)),
    .DEPTH(dsbo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(s_valid),
    .in_ready(s_ready),
    .in_data(s_data),
    .out_valid(f_valid),
    .out_ready(rise),
    .out_data(f_data)
  );

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smp_r <= '0;
    end
    else if (rise && f_valid)
    begin
      smp_r <= f_data;
    end
  end

  // an empty fifo repeats the last sample
  assign vin = (f_valid ? f_data.vin_mv : smp_r.vin_mv);
  assign pos_clip = (vin >= dsbo_pkg::CLIP_MV);
  assign neg_clip = (vin <= -dsbo_pkg::CLIP_MV);

  // second-order loop, dac at +-clip so density is (v+clip)/(2*clip)
  assign fb = ext_mv(bit_r ? dsbo_pkg::CLIP_MV : -dsbo_pkg::CLIP_MV);
  assign i1_nxt = i1_r + ext_mv(vin) - fb;
  assign i2_nxt = i2_r + i1_nxt - (fb <<< 1);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clipped_r <= 1'b0;
      clip_pos_r <= 1'b0;
      mark_cnt_r <= '0;
    end
    else if (rise)
    begin
      clipped_r <= pos_clip || neg_clip;
      clip_pos_r <= pos_clip;
      if ((pos_clip || neg_clip) && clipped_r && (clip_pos_r == pos_clip))
      begin
        mark_cnt_r <= mark_cnt_r + 1'b1;
      end
      else
      begin
        mark_cnt_r <= '0;
      end
    end
  end

  // integrators are parked while clipped so recovery starts clean
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      i1_r <= '0;
      i2_r <= '0;
      bit_r <= 1'b0;
    end
    else if (rise)
    begin
      if (pos_clip || neg_clip)
      begin
        i1_r <= '0;
        i2_r <= '0;
        if (clipped_r && (clip_pos_r == pos_clip) &&
            (mark_cnt_r == dsbo_pkg::MARK_LAST))
        begin
          bit_r <= !pos_clip;
        end
        else
        begin
          bit_r <= pos_clip;
        end
      end
      else
      begin
        i1_r <= i1_nxt;
        i2_r <= i2_nxt;
        bit_r <= !i2_nxt[AW-1];
      end
    end
  end

  // trip sampled on clock edges so a stopped clock still freezes
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fs_r <= 1'b0;
    end
    else if (rise)
    begin
      fs_r <= cm_s_r.low_trip || cm_s_r.high_trip;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inv_r <= 1'b0;
    end
    else if (mode_chg)
    begin
      inv_r <= clk_s_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dout_r <= 1'b0;
    end
    else if (fs_r)
    begin
      dout_r <= 1'b1;
    end
    else if (mode_s_r)
    begin
      dout_r <= bit_r ^ clk_s_r ^ inv_r;
    end
    else
    begin
      dout_r <= bit_r ^ inv_r;
    end
  end

  assign bitstream_out = dout_r;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chop_cnt_r <= '0;
      chop_r <= 1'b0;
    end
    else if (rise)
    begin
      chop_cnt_r <= chop_cnt_r + 1'b1;
      if (chop_cnt_r == dsbo_pkg::CHOP_LAST)
      begin
        chop_r <= !chop_r;
      end
    end
  end

  assign chopper_phase = chop_r;

  // missing edges for two slow periods mean the clock has stopped
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pause_cnt_r <= PAUSE_LIM;
    end
    else if (rise)
    begin
      pause_cnt_r <= '0;
    end
    else if (pause_cnt_r != PAUSE_LIM)
    begin
      pause_cnt_r <= pause_cnt_r + 1'b1;
    end
  end

  assign alive = (pause_cnt_r != PAUSE_LIM);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      settle_cnt_r <= '0;
      settled_r <= 1'b0;
      active_r <= 1'b0;
    end
    else
    begin
      active_r <= alive;
      settled_r <= alive && (settle_cnt_r == SETTLE_LAST);
      if (!alive)
      begin
        settle_cnt_r <= '0;
      end
      else if (settle_cnt_r != SETTLE_LAST)
      begin
        settle_cnt_r <= settle_cnt_r + 1'b1;
      end
    end
  end

  assign conversion_active = active_r;
  assign stream_settled = settled_r;

  default clocking dflt_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_bit_on_rise: assert property (
    bit_r != $past(bit_r) |-> $past(rise))
    else $error("modulator bit changed without a clock rise");
  a_clip_ones: assert property (
    rise && pos_clip && clipped_r && clip_pos_r &&
    mark_cnt_r != dsbo_pkg::MARK_LAST |=> bit_r)
    else $error("positive clipping did not give a one");
  a_marker_pos: assert property (
    rise && pos_clip && clipped_r && clip_pos_r &&
    mark_cnt_r == dsbo_pkg::MARK_LAST |=> !bit_r)
    else $error("positive clipping marker zero missing");
  a_marker_neg: assert property (
    rise && neg_clip && clipped_r && !clip_pos_r &&
    mark_cnt_r == dsbo_pkg::MARK_LAST |=> bit_r)
    else $error("negative clipping marker one missing");
  a_marker_restart: assert property (
    $rose(clipped_r) |-> mark_cnt_r == '0)
    else $error("marker count not restarted on clipping");
  a_failsafe_high: assert property (
    fs_r ##1 fs_r |-> dout_r ##1 dout_r)
    else $error("fail-safe output not held high");
  a_failsafe_coded: assert property (
    fs_r && mode_s_r |=> dout_r)
    else $error("fail-safe lost to coded stream");
  a_coded_xor: assert property (
    !fs_r && mode_s_r |=> dout_r == $past(bit_r ^ clk_s_r ^ inv_r))
    else $error("coded output is not clock xor bit");
  a_invert_mode: assert property (
    mode_chg && clk_s_r |=> inv_r)
    else $error("mode change while clock high did not invert");
  a_chop_toggle: assert property (
    rise && chop_cnt_r == dsbo_pkg::CHOP_LAST |=> $changed(chop_r))
    else $error("chopper did not switch after 16 edges");
  a_frozen_stop: assert property (
    (!rise && !mode_chg && $stable(clk_s_r))[*3] |=> $stable(dout_r))
    else $error("output moved while the sample clock was stopped");

  c_clip_marker: cover property (
    rise && clipped_r && mark_cnt_r == dsbo_pkg::MARK_LAST);
  c_failsafe: cover property ($rose(fs_r));
  c_coded: cover property (mode_s_r && rise && !fs_r);
  c_settled: cover property ($rose(settled_r));
endmodule // dsbo_top

// >>> inc/dsbo_pkg.sv
// constants and carrier types for the delta-sigma bitstream output block
package dsbo_pkg;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 24;
  localparam int MARK_W = 7;
  localparam int CHOP_W = 4;
  localparam int PAUSE_W = 8;
  localparam int SETTLE_W = 17;
  localparam int FIFO_DEPTH = 32;

  // differential input in millivolts, two's complement
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] vin_mv;
  } dsbo_sample_t;

  // common-mode detector outputs
  typedef struct packed {
    logic low_trip;
    logic high_trip;
  } dsbo_cm_t;

  // clipping magnitude, 1250 mV
  localparam logic signed [SAMPLE_W-1:0] CLIP_MV = 16'sh04E2;
  // marker every 128 sample clocks
  localparam logic [MARK_W-1:0] MARK_LAST = 7'h7F;
  // chopper half period of 16 sample clocks, full period 32
  localparam logic [CHOP_W-1:0] CHOP_LAST = 4'hF;

  localparam real CLK_PERIOD_NS = 4.0;
  localparam real BIAS_SETTLE_MS = 0.25;
  localparam int SETTLE_CYCLES =
    int'($ceil(BIAS_SETTLE_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam real MIN_SAMPLE_MHZ = 9.0;
  // twice the slowest legal sample clock period
  localparam int PAUSE_CYCLES =
    2 * int'($ceil(1.0E3 / MIN_SAMPLE_MHZ / CLK_PERIOD_NS));
endpackage

// >>> test/dsbo_filter_model.sv
// decimating filter side: sample clock source and window ones counter
`timescale 1ns/1ps

module dsbo_filter_model #(
  parameter logic [3:0] HI = 4'h4,
  parameter logic [3:0] LO = 4'h8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control from the bench
  input wire logic run,
  input wire logic start,
  input wire logic per_cycle,
  input wire logic [9:0] len,
  // link
  input wire logic bitstream_out,
  output logic sample_clock_in,
  // result
  output logic done,
  output logic [11:0] cnt,
  output logic [15:0] word
);
  logic [3:0] ph_r;
  logic [24:0] acc1_r;
  logic [24:0] acc2_r;
  logic [24:0] acc3_r;
  logic [24:0] z1_r;
  logic [24:0] z2_r;
  logic [24:0] z3_r;
  logic [24:0] k1;
  logic [24:0] k2;
  logic [24:0] k3;
  logic [7:0] dec_r;
  logic [9:0] left_r;
  logic arm_r;
  logic rise;

  // 12 ref cycles per period, about 20.8 mhz
  assign rise = run && !sample_clock_in && ph_r == LO - 4'h1;

  // stopped clock stands still at its last level
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      sample_clock_in <= 1'b0;
      ph_r <= 4'h0;
    end
    else if (!run)
      ph_r <= 4'h0;
    else if (sample_clock_in ? ph_r == HI - 4'h1 : rise)
    begin
      sample_clock_in <= !sample_clock_in;
      ph_r <= 4'h0;
    end
    else
      ph_r <= ph_r + 4'h1;

  // plain mode latches on rise, coded mode counts high ref cycles
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      done <= 1'b0;
      arm_r <= 1'b0;
      left_r <= 10'h000;
      cnt <= 12'h000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        arm_r <= 1'b1;
        left_r <= 10'h000;
        cnt <= 12'h000;
      end
      else if (rise && arm_r)
      begin
        arm_r <= 1'b0;
        left_r <= len;
      end
      else if (left_r != 10'h000)
      begin
        if (per_cycle)
          cnt <= cnt + {11'h000, bitstream_out};
        if (rise)
        begin
          if (!per_cycle)
            cnt <= cnt + {11'h000, bitstream_out};
          left_r <= left_r - 10'h001;
          done <= left_r == 10'h001;
        end
      end
    end

  // combs run once per 256 rises; full scale 2**24 saturates to all ones
  assign k1 = acc3_r - z1_r;
  assign k2 = k1 - z2_r;
  assign k3 = k2 - z3_r;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      acc1_r <= '0;
      acc2_r <= '0;
      acc3_r <= '0;
      z1_r <= '0;
      z2_r <= '0;
      z3_r <= '0;
      dec_r <= 8'h00;
      word <= 16'h0000;
    end
    else if (rise)
    begin
      acc1_r <= acc1_r + {24'h000000, bitstream_out};
      acc2_r <= acc2_r + acc1_r;
      acc3_r <= acc3_r + acc2_r;
      dec_r <= dec_r + 8'h01;
      if (dec_r == 8'hFF)
      begin
        z1_r <= acc3_r;
        z2_r <= k1;
        z3_r <= k2;
        word <= k3[24] ? 16'hFFFF : k3[23:8];
      end
    end
endmodule // dsbo_filter_model

// >>> test/delta_sigma_bitstream_output_test.sv
// self-checking bench for the bitstream output stage
`timescale 1ns/1ps

module delta_sigma_bitstream_output_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sample_clock_in, line_code_select, s_valid, s_ready;
  logic bitstream_out, chopper_phase, conversion_active, stream_settled;
  dsbo_pkg::dsbo_cm_t cm_trip;
  dsbo_pkg::dsbo_sample_t s_data;
  logic run, start, per_cycle, done, b;
  logic [9:0] win_len;
  logic [11:0] cnt;
  logic [15:0] word;
  logic [11:0] lo_q[$];
  logic [11:0] hi_q[$];
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int vin_t[6] = '{0, 1000, -1000, 1250, -1250, -500};
  int lo_t[6] = '{124, 226, 21, 254, 2, 73};
  int hi_t[6] = '{132, 235, 30, 254, 2, 81};

  always #2 ref_clk = ~ref_clk;

  dsbo_top #(.SETTLE_CYCLES(20)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .sample_clock_in(sample_clock_in),
    .line_code_select(line_code_select), .cm_trip(cm_trip),
    .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
    .bitstream_out(bitstream_out), .chopper_phase(chopper_phase),
    .conversion_active(conversion_active),
    .stream_settled(stream_settled));

  dsbo_filter_model filt (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(run), .start(start),
    .per_cycle(per_cycle), .len(win_len),
    .bitstream_out(bitstream_out), .sample_clock_in(sample_clock_in),
    .done(done), .cnt(cnt), .word(word));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // count window over len periods, range noted for the watcher
  task automatic win(input int len, input logic pc, input int lo, input int hi);
    @(posedge ref_clk);
    lo_q.push_back(12'(lo));
    hi_q.push_back(12'(hi));
    win_len <= 10'(len);
    per_cycle <= pc;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    @(posedge ref_clk iff done);
  endtask

  task automatic rises(input int k);
    repeat (k) @(posedge sample_clock_in);
    @(posedge ref_clk);
  endtask

  // watcher takes the oldest note when a window closes
  always @(posedge ref_clk)
    if (done)
    begin
      logic [11:0] lo, hi;
      lo = lo_q.pop_front();
      hi = hi_q.pop_front();
      check((cnt >= lo && cnt <= hi) ? lo : cnt, lo);
    end

  // hang guard sized well above the planned run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    {run, start, per_cycle, line_code_select, s_valid} = 5'h00;
    win_len = 10'h000;
    cm_trip = 2'h0;
    s_data = 16'sh0000;
    void'($urandom(65));
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    // no sample clock yet: fifo must fill and refuse
    @(posedge ref_clk);
    s_valid <= 1'b1;
    n = 0;
    repeat (40)
    begin
      @(posedge ref_clk);
      if (s_valid && s_ready)
        n++;
      s_data <= 16'($urandom_range(2000) - 1000);
    end
    check(12'(n), 12'(dsbo_pkg::FIFO_DEPTH));
    check({11'h000, conversion_active}, 12'h000);
    run <= 1'b1;
    while (!stream_settled) @(posedge ref_clk);
    check({11'h000, conversion_active}, 12'h001);
    for (int i = 0; i < 6; i++)
    begin
      s_data <= 16'(vin_t[i]);
      rises(64);
      win(256, 1'b0, lo_t[i], hi_t[i]);
      // filtered word needs three full decimations of steady input
      if (i == 1 || i == 2)
      begin
        rises(800);
        n = (i == 1) ? 58982 : 6553;
        check(12'(word > n - 48 && word < n + 48), 12'h001);
      end
    end
    for (int i = 1; i < 3; i++)
    begin
      cm_trip <= 2'(i);
      rises(8);
      win(256, 1'b0, 256, 256);
      cm_trip <= 2'h0;
      rises(8);
    end
    // negative clipping, past the fifo's 32 words of latency
    s_data <= 16'hFB1E;
    rises(40);
    // coded clipped stream: four high cycles a period, one marker
    @(negedge sample_clock_in);
    repeat (2) @(posedge ref_clk);
    line_code_select <= 1'b1;
    rises(8);
    win(128, 1'b1, 516, 516);
    @(negedge sample_clock_in);
    repeat (2) @(posedge ref_clk);
    line_code_select <= 1'b0;
    rises(4);
    // mode change while clock high inverts the coded stream
    @(posedge sample_clock_in);
    @(posedge ref_clk);
    line_code_select <= 1'b1;
    rises(8);
    win(128, 1'b1, 1020, 1020);
    @(negedge sample_clock_in);
    repeat (2) @(posedge ref_clk);
    line_code_select <= 1'b0;
    rises(4);
    // chopper flips every 16 rises
    rises(1);
    repeat (5) @(posedge ref_clk);
    b = chopper_phase;
    rises(16);
    repeat (5) @(posedge ref_clk);
    check({11'h000, chopper_phase}, {11'h000, ~b});
    // stopped clock freezes output level
    run <= 1'b0;
    repeat (10) @(posedge ref_clk);
    b = bitstream_out;
    repeat (60) @(posedge ref_clk);
    check({11'h000, bitstream_out}, {11'h000, b});
    check({11'h000, conversion_active}, 12'h000);
    test_done();
  end
endmodule // delta_sigma_bitstream_output_test
